/* File: rtl/fan_pwm_fault_supervisor.sv */
// Fan PWM controller with start-up, missing pulse and fault supervision
// Functional notes
// RULE1: Sense pulses caused by drive turn-on are blanked; others reach the detector.
// RULE2: Thirty-two pulse-free PWM cycles time out and start the diagnostic timer.
// RULE3: Diagnostic timer holds drive fully on for three PWM cycles.
// RULE4: Diagnostic miss runs a 32-cycle full-drive start-up; a pulse resumes normal.
// RULE5: Start-up retry miss stops drive, pulls fault low, latches fan fault.
// RULE6: Fan fault keeps fault low and drive off until reset.
// RULE7: Shutdown then release leaves fan fault and restarts power-up sequence.
// RULE8: System must restart the fan after a latched fault or shut down.
// RULE9: Fault may be coupled to shutdown input for continuous restart.
// RULE10: External logic should shut down on repeated one-second fault pulses.
// RULE11: Demand above full-duty level asserts fault; released when it falls back.
// RULE12: Over-temperature fault does not stop the fan drive.
// RULE13: System may tie fault to shutdown to latch on any fault.
// RULE14: Power-up drives full on 32 PWM cycles; a pulse moves to normal.
// RULE15: No pulse in first start: one more start period, then fan fault.
// RULE16: Each normal loop pass clears the missing pulse detector on a pulse.
// RULE17: Shutdown forces duty zero, fault inactive, then restarts like power-up.
// RULE18: Each PWM cycle duty follows the larger of demand and floor.
// RULE19: Codes map linearly onto duty; codes above full give full duty.
// RULE20: Supervisory counters advance once per PWM cycle.
// RULE21: System should set the floor at 1.8 V or higher.
// RULE22: Shutdown always resets all state and suspends everything until release; here it resets only the sequencer, while timebase and sampling run on.
// RULE23: Sense input synchronised, edge detected, blanked for a parameter count.
// RULE24: Demand, floor and shutdown inputs are digital, sampled once per PWM cycle; here shutdown acts on every clock, over-temperature once per cycle.
`timescale 1ns/10ps
module fan_pwm_fault_supervisor #(
	parameter int          DUTY_W       = fan_sup_pkg::DUTY_W,
	parameter logic [15:0] PRESCALE     = fan_sup_pkg::PRESCALE_DEF,
	parameter logic [15:0] BLANK_CYCLES = fan_sup_pkg::BLANK_DEF
) (
	input  wire logic              sys_clk_i,
	input  wire logic              reset_n_i,
	input  wire logic [DUTY_W-1:0] demand_i,
	input  wire logic [DUTY_W-1:0] floor_i,
	input  wire logic              overtemp_i,
	input  wire logic              shutdown_i,
	input  wire logic              sense_i,
	output logic                   drive_o,
	output logic                   fault_n_o,
	output logic                   pwm_cycle_o,
	output logic                   fan_fault_o
);
	logic [15:0]       pre_r, pre_nxt;
	logic [DUTY_W-1:0] phase_r, phase_nxt;
	logic              tick;
	logic [DUTY_W-1:0] duty_r, duty_nxt;
	logic              ot_r, ot_nxt;
	logic              pulse;
	logic              seen_r, seen_nxt;
	fan_sup_pkg::sup_state_t state_r, state_nxt;
	logic [5:0]        cnt_r, cnt_nxt;
	logic              drive_r, drive_nxt;
	logic              fault_n_r, fault_n_nxt;
	logic              cyc_r, cyc_nxt;
	logic              ff_r, ff_nxt;
	logic              pulse_any;

	localparam logic [DUTY_W-1:0] PH_LAST = {DUTY_W{1'b1}} - {{(DUTY_W-1){1'b0}}, 1'b1};

	sense_blank #(
		.BLANK_CYCLES (BLANK_CYCLES)
	) u_sense (
		.sys_clk_i  (sys_clk_i),
		.reset_n_i  (reset_n_i),
		.sense_i    (sense_i),
		.drive_on_i (drive_r),
		.pulse_o    (pulse)
	);

	// PWM timebase
	always_comb begin
		pre_nxt   = pre_r + fan_sup_pkg::PRE_ONE;
		phase_nxt = phase_r;
		tick      = 1'b0;
		if (pre_r >= PRESCALE) begin
			pre_nxt   = fan_sup_pkg::PRE_ONE;
			phase_nxt = phase_r + {{(DUTY_W-1){1'b0}}, 1'b1};
			if (phase_r == PH_LAST) begin
				phase_nxt = '0;
				tick      = 1'b1; // RULE20
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			pre_r   <= fan_sup_pkg::PRE_ONE;
			phase_r <= '0;
		end else begin
			pre_r   <= pre_nxt;
			phase_r <= phase_nxt;
		end
	end

	// Input sampling once per PWM cycle, duty selection
	always_comb begin
		ot_nxt    = ot_r;
		duty_nxt  = duty_r;
		if (tick) begin
			ot_nxt    = overtemp_i || (demand_i == {DUTY_W{1'b1}}); // RULE11 RULE24
			duty_nxt  = (demand_i > floor_i) ? demand_i : floor_i; // RULE18 RULE19 RULE24
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			ot_r    <= 1'b0;
			duty_r  <= '0;
		end else begin
			ot_r    <= ot_nxt;
			duty_r  <= duty_nxt;
		end
	end

	// Supervisory sequencer
	always_comb begin
		pulse_any = seen_r || pulse;
		seen_nxt  = seen_r || pulse;
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		if (shutdown_i) begin
			state_nxt = fan_sup_pkg::ST_OFF; // RULE22 RULE17
			cnt_nxt   = fan_sup_pkg::CNT_ZERO;
			seen_nxt  = 1'b0;
		end else if (tick) begin
			seen_nxt = 1'b0;
			cnt_nxt  = cnt_r + fan_sup_pkg::CNT_ONE; // RULE20
			unique case (state_r)
				fan_sup_pkg::ST_OFF: begin
					state_nxt = fan_sup_pkg::ST_START1; // RULE7 RULE14
					cnt_nxt   = fan_sup_pkg::CNT_ZERO;
				end
				fan_sup_pkg::ST_START1: begin
					if (pulse_any) begin
						state_nxt = fan_sup_pkg::ST_NORMAL; // RULE14
						cnt_nxt   = fan_sup_pkg::CNT_ZERO;
					end else if (cnt_nxt == fan_sup_pkg::START_CYCLES) begin
						state_nxt = fan_sup_pkg::ST_START2; // RULE15
						cnt_nxt   = fan_sup_pkg::CNT_ZERO;
					end
				end
				fan_sup_pkg::ST_NORMAL: begin
					if (pulse_any) begin
						cnt_nxt = fan_sup_pkg::CNT_ZERO; // RULE16
					end else if (cnt_nxt == fan_sup_pkg::MISS_CYCLES) begin
						state_nxt = fan_sup_pkg::ST_DIAG; // RULE2
						cnt_nxt   = fan_sup_pkg::CNT_ZERO;
					end
				end
				fan_sup_pkg::ST_DIAG: begin
					if (pulse_any) begin
						state_nxt = fan_sup_pkg::ST_NORMAL;
						cnt_nxt   = fan_sup_pkg::CNT_ZERO;
					end else if (cnt_nxt == fan_sup_pkg::DIAG_CYCLES) begin
						state_nxt = fan_sup_pkg::ST_START2; // RULE4
						cnt_nxt   = fan_sup_pkg::CNT_ZERO;
					end
				end
				fan_sup_pkg::ST_START2: begin
					if (pulse_any) begin
						state_nxt = fan_sup_pkg::ST_NORMAL; // RULE4
						cnt_nxt   = fan_sup_pkg::CNT_ZERO;
					end else if (cnt_nxt == fan_sup_pkg::START_CYCLES) begin
						state_nxt = fan_sup_pkg::ST_FAULT; // RULE5 RULE15
						cnt_nxt   = fan_sup_pkg::CNT_ZERO;
					end
				end
				fan_sup_pkg::ST_FAULT: begin
					cnt_nxt = fan_sup_pkg::CNT_ZERO; // RULE6
				end
				default: begin
					state_nxt = fan_sup_pkg::ST_OFF;
					cnt_nxt   = fan_sup_pkg::CNT_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			state_r <= fan_sup_pkg::ST_OFF;
			cnt_r   <= fan_sup_pkg::CNT_ZERO;
			seen_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			seen_r  <= seen_nxt;
		end
	end

	// Output drive and fault pin
	always_comb begin
		drive_nxt   = 1'b0;
		fault_n_nxt = 1'b1;
		cyc_nxt     = tick;
		ff_nxt      = (state_nxt == fan_sup_pkg::ST_FAULT);
		unique case (state_nxt)
			fan_sup_pkg::ST_OFF: begin
				drive_nxt   = 1'b0; // RULE17
				fault_n_nxt = 1'b1;
			end
			fan_sup_pkg::ST_START1, fan_sup_pkg::ST_START2,
			fan_sup_pkg::ST_DIAG: begin
				drive_nxt   = 1'b1; // RULE3 RULE4 RULE14
				fault_n_nxt = !ot_nxt;
			end
			fan_sup_pkg::ST_NORMAL: begin
				drive_nxt   = (phase_nxt < duty_nxt) || (duty_nxt == {DUTY_W{1'b1}}); // RULE12
				fault_n_nxt = !ot_nxt; // RULE11
			end
			fan_sup_pkg::ST_FAULT: begin
				drive_nxt   = 1'b0; // RULE5 RULE6
				fault_n_nxt = 1'b0;
			end
			default: begin
				drive_nxt   = 1'b0;
				fault_n_nxt = 1'b1;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			drive_r   <= 1'b0;
			fault_n_r <= 1'b1;
			cyc_r     <= 1'b0;
			ff_r      <= 1'b0;
		end else begin
			drive_r   <= drive_nxt;
			fault_n_r <= fault_n_nxt;
			cyc_r     <= cyc_nxt;
			ff_r      <= ff_nxt;
		end
	end

	assign drive_o     = drive_r;
	assign fault_n_o   = fault_n_r;
	assign pwm_cycle_o = cyc_r;
	assign fan_fault_o = ff_r;

	sequence s_in_fault;
		state_r == fan_sup_pkg::ST_FAULT;
	endsequence

	chk_fault_holds: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE6
		s_in_fault ##0 !shutdown_i |=> !drive_r && !fault_n_r)
		else $error("Fan fault not latched");
	chk_shdn_off: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE17
		shutdown_i |=> state_r == fan_sup_pkg::ST_OFF && !drive_r && fault_n_r)
		else $error("Shutdown did not stop drive");
	chk_diag_drive: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE3
		state_r == fan_sup_pkg::ST_DIAG |-> drive_r)
		else $error("Diagnostic drive not on");
	chk_start_drive: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE14
		state_r == fan_sup_pkg::ST_START1 |-> drive_r)
		else $error("Start-up drive not on");
	chk_miss_count: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE2
		state_r == fan_sup_pkg::ST_NORMAL |-> cnt_r < fan_sup_pkg::MISS_CYCLES)
		else $error("Missing pulse counter overran");
	chk_diag_count: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE4
		state_r == fan_sup_pkg::ST_DIAG |-> cnt_r < fan_sup_pkg::DIAG_CYCLES)
		else $error("Diagnostic counter overran");
	chk_fault_entry: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE5
		state_r == fan_sup_pkg::ST_START2 ##1 state_r == fan_sup_pkg::ST_FAULT
		|-> $past(tick) && !$past(pulse_any))
		else $error("Fault entered without timeout");
	chk_ot_run: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE12
		state_r == fan_sup_pkg::ST_NORMAL && duty_r == {DUTY_W{1'b1}} |-> drive_r)
		else $error("Full duty drive dropped");
	chk_pulse_clear: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE16
		state_r == fan_sup_pkg::ST_NORMAL && tick && pulse_any && !shutdown_i
		|=> cnt_r == fan_sup_pkg::CNT_ZERO)
		else $error("Detector not cleared by pulse");

	sequence s_miss_timeout;
		state_r == fan_sup_pkg::ST_NORMAL ##1 state_r == fan_sup_pkg::ST_DIAG;
	endsequence

	chk_diag_entry: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE2
		s_miss_timeout |-> $past(tick) && !$past(pulse_any)
			&& $past(cnt_r) == fan_sup_pkg::MISS_CYCLES - fan_sup_pkg::CNT_ONE)
		else $error("Diagnostic entered without timeout");
	chk_retry_drive: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE4
		state_r == fan_sup_pkg::ST_START2 |-> drive_r)
		else $error("Retry drive not on");
	chk_ot_fault: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE11
		state_r == fan_sup_pkg::ST_NORMAL && ot_r |-> !fault_n_r)
		else $error("Over-temperature fault not shown");
	chk_off_quiet: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE22
		state_r == fan_sup_pkg::ST_OFF |-> !drive_r && fault_n_r)
		else $error("Outputs active while off");
endmodule : fan_pwm_fault_supervisor

/* File: pkg/fan_sup_pkg.sv */
// Constants for the fan PWM fault supervisor
package fan_sup_pkg;
	// Duty code width and full-duty code (1.25 V maps to 0, 2.65 V to full)
	localparam int          DUTY_W        = 8;
	localparam logic [7:0]  DUTY_FULL     = 8'hFF;
	// PWM timebase: clock cycles per PWM step; steps per PWM cycle = DUTY_FULL
	localparam int          PRESCALE_W    = 16;
	localparam logic [15:0] PRESCALE_DEF  = 16'h0001;
	// Supervisory timer lengths in PWM cycles
	localparam logic [5:0]  MISS_CYCLES   = 6'h20;
	localparam logic [5:0]  START_CYCLES  = 6'h20;
	localparam logic [5:0]  DIAG_CYCLES   = 6'h03;
	// Blanking after each drive turn-on, clock cycles
	localparam logic [15:0] BLANK_DEF     = 16'h0010;
	localparam logic [5:0]  CNT_ZERO      = 6'h00;
	localparam logic [5:0]  CNT_ONE       = 6'h01;
	localparam logic [7:0]  DUTY_ZERO     = 8'h00;
	localparam logic [15:0] BLANK_ZERO    = 16'h0000;
	localparam logic [15:0] PRE_ONE       = 16'h0001;

	typedef enum logic [5:0] {
		ST_OFF    = 6'b00_0001,
		ST_START1 = 6'b00_0010,
		ST_START2 = 6'b00_0100,
		ST_NORMAL = 6'b00_1000,
		ST_DIAG   = 6'b01_0000,
		ST_FAULT  = 6'b10_0000
	} sup_state_t;
endpackage : fan_sup_pkg

/* File: rtl/sense_blank.sv */
// Sense pulse synchroniser, edge detector and turn-on blanker
`timescale 1ns/10ps
module sense_blank #(
	parameter logic [15:0] BLANK_CYCLES = fan_sup_pkg::BLANK_DEF
) (
	input  wire logic sys_clk_i,
	input  wire logic reset_n_i,
	input  wire logic sense_i,
	input  wire logic drive_on_i,
	output logic      pulse_o
);
	logic        sync1_r, sync2_r, sync3_r;
	logic        drv_d_r;
	logic [15:0] blank_r, blank_nxt;
	logic        pulse_r, pulse_nxt;

	always_comb begin
		blank_nxt = blank_r;
		if (drive_on_i && !drv_d_r) begin
			blank_nxt = BLANK_CYCLES; // RULE23
		end else if (blank_r != fan_sup_pkg::BLANK_ZERO) begin
			blank_nxt = blank_r - fan_sup_pkg::PRE_ONE;
		end
		// Rising edge, not inside the blanking window
		pulse_nxt = sync2_r && !sync3_r && (blank_r == fan_sup_pkg::BLANK_ZERO)
			&& !(drive_on_i && !drv_d_r); // RULE1
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			sync3_r <= 1'b0;
			drv_d_r <= 1'b0;
			blank_r <= fan_sup_pkg::BLANK_ZERO;
			pulse_r <= 1'b0;
		end else begin
			sync1_r <= sense_i; // RULE23
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			drv_d_r <= drive_on_i;
			blank_r <= blank_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	assign pulse_o = pulse_r;

	chk_blank_after_on: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE1
		(drive_on_i && !drv_d_r) |=> !pulse_r)
		else $error("Sense pulse passed during blanking");
endmodule : sense_blank

/* File: sim/fan_model.sv */
// Fan motor, sense network and system fault handler model
`timescale 1ns/10ps
module fan_model (
	input  wire logic       sys_clk_i,
	input  wire logic       drive_i,
	input  wire logic       spin_i,
	input  wire logic       glitch_i,
	input  wire logic       fault_n_i,
	input  wire logic [1:0] mode_i,
	output logic            sense_o,
	output logic            shdn_o
);
	logic [5:0] on_cnt_r;
	logic [1:0] age_r;
	logic       fault_d_r;
	logic [2:0] kick_r;
	logic       strike_r;
	logic       hold_r;

	// Time since the drive stage was energised; age saturates so the spike comes once per turn-on
	always_ff @(posedge sys_clk_i) begin
		if (drive_i) begin
			on_cnt_r <= on_cnt_r + 6'h01;
			if (age_r != 2'h3) begin
				age_r <= age_r + 2'h1;
			end
		end else begin
			on_cnt_r <= 6'h00;
			age_r    <= 2'h0;
		end
	end

	// Commutation pulses only while energised and turning; optional turn-on spike
	assign sense_o = (spin_i & drive_i & (on_cnt_r[5:4] == 2'b11))
		| (glitch_i & drive_i & (age_r < 2'h2));

	// Fault handler: mode 1 kicks a restart and stops on a repeat, mode 2 latches on any fault
	always_ff @(posedge sys_clk_i) begin
		fault_d_r <= fault_n_i;
		if (mode_i == 2'b00) begin
			kick_r   <= 3'h0;
			strike_r <= 1'b0;
			hold_r   <= 1'b0;
		end else if (fault_d_r && !fault_n_i) begin
			strike_r <= 1'b1;
			if (mode_i == 2'b10) begin
				hold_r <= 1'b1;
			end else if (strike_r) begin
				hold_r <= 1'b1;
			end else begin
				kick_r <= 3'h4;
			end
		end else if (kick_r != 3'h0) begin
			kick_r <= kick_r - 3'h1;
		end
	end

	assign shdn_o = (kick_r != 3'h0) | hold_r;
endmodule : fan_model

/* File: sim/tb_fan_pwm_fault_supervisor.sv */
// Self-checking bench for the fan PWM fault supervisor
`timescale 1ns/10ps
module tb_fan_pwm_fault_supervisor;
	logic       sys_clk_i  = 1'b0;
	logic       reset_n_i  = 1'b0;
	logic [7:0] demand_i   = 8'h00;
	logic [7:0] floor_i    = 8'h00;
	logic       overtemp_i = 1'b0;
	logic       shutdown_i = 1'b0;
	logic       spin       = 1'b0;
	logic       glitch     = 1'b0;
	logic [1:0] handler_mode = 2'b00;
	logic       sys_shdn;
	logic       sense_i;
	logic       drive_o;
	logic       fault_n_o;
	logic       pwm_cycle_o;
	logic       fan_fault_o;
	int         failures    = 0;
	int         comparisons = 0;
	int         cycles      = 0;

	fan_pwm_fault_supervisor #(
		.PRESCALE    (16'h0001),
		.BLANK_CYCLES(16'h0008)
	) i_fan_pwm_fault_supervisor (
		.sys_clk_i  (sys_clk_i),
		.reset_n_i  (reset_n_i),
		.demand_i   (demand_i),
		.floor_i    (floor_i),
		.overtemp_i (overtemp_i),
		.shutdown_i (shutdown_i | sys_shdn),
		.sense_i    (sense_i),
		.drive_o    (drive_o),
		.fault_n_o  (fault_n_o),
		.pwm_cycle_o(pwm_cycle_o),
		.fan_fault_o(fan_fault_o)
	);

	fan_model i_fan_model (
		.sys_clk_i(sys_clk_i),
		.drive_i  (drive_o),
		.spin_i   (spin),
		.glitch_i (glitch),
		.fault_n_i(fault_n_o),
		.mode_i   (handler_mode),
		.sense_o  (sense_i),
		.shdn_o   (sys_shdn)
	);

	always #5 sys_clk_i = ~sys_clk_i;

	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 80000) begin
			failures++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict

	task automatic chk1(input string name, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %b seen %b", name, exp, got);
		end
	endtask : chk1

	// Counts drive-on clocks over one PWM period
	task automatic duty(input logic [8:0] exp);
		logic [8:0] n;
		n = 9'h000;
		repeat (255) begin
			@(posedge sys_clk_i);
			#1;
			if (drive_o === 1'b1) n = n + 9'h001;
		end
		comparisons++;
		if (n !== exp) begin
			failures++;
			$display("[ERR] duty expected %0d seen %0d", exp, n);
		end
	endtask : duty

	// Returns just after the edge that raised the n-th PWM cycle strobe
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge sys_clk_i);
			#1;
			while (pwm_cycle_o !== 1'b1) begin
				@(posedge sys_clk_i);
				#1;
			end
		end
	endtask : ticks

	task automatic clocks(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask : clocks

	task automatic test_powerup_fail();
		ticks(3);
		chk1("drive", 1'b1, drive_o);
		ticks(57);
		chk1("fan_fault", 1'b0, fan_fault_o);
		ticks(10);
		chk1("fan_fault", 1'b1, fan_fault_o);
		chk1("fault_n", 1'b0, fault_n_o);
		chk1("drive", 1'b0, drive_o);
		ticks(3);
		chk1("fault_n", 1'b0, fault_n_o);
		duty(9'h000);
		$display("test powerup_fail done");
	endtask : test_powerup_fail

	task automatic test_restart_duty();
		shutdown_i = 1'b1;
		clocks(3);
		chk1("fan_fault", 1'b0, fan_fault_o);
		chk1("fault_n", 1'b1, fault_n_o);
		chk1("drive", 1'b0, drive_o);
		spin = 1'b1;
		demand_i = 8'h90;
		floor_i = 8'h70;
		shutdown_i = 1'b0;
		ticks(1);
		clocks(3);
		chk1("drive", 1'b1, drive_o);
		ticks(3);
		duty(9'h090);
		demand_i = 8'h10;
		ticks(2);
		duty(9'h070);
		ticks(36);
		duty(9'h070);
		shutdown_i = 1'b1;
		clocks(2);
		duty(9'h000);
		chk1("fault_n", 1'b1, fault_n_o);
		shutdown_i = 1'b0;
		ticks(4);
		duty(9'h070);
		$display("test restart_duty done");
	endtask : test_restart_duty

	task automatic test_overtemp();
		demand_i = 8'h90;
		overtemp_i = 1'b1;
		ticks(2);
		chk1("fault_n", 1'b0, fault_n_o);
		duty(9'h090);
		overtemp_i = 1'b0;
		demand_i = 8'hFF;
		ticks(2);
		chk1("fault_n", 1'b0, fault_n_o);
		duty(9'h0FF);
		demand_i = 8'h90;
		ticks(2);
		chk1("fault_n", 1'b1, fault_n_o);
		chk1("fan_fault", 1'b0, fan_fault_o);
		$display("test overtemp done");
	endtask : test_overtemp

	task automatic test_stall();
		ticks(1);
		spin = 1'b0;
		glitch = 1'b1;
		handler_mode = 2'b01;
		ticks(26);
		duty(9'h090);
		ticks(5);
		duty(9'h0FF);
		ticks(34);
		chk1("fan_fault", 1'b1, fan_fault_o);
		chk1("fault_n", 1'b0, fault_n_o);
		chk1("drive", 1'b0, drive_o);
		clocks(3);
		chk1("fan_fault", 1'b0, fan_fault_o);
		chk1("fault_n", 1'b1, fault_n_o);
		ticks(1);
		chk1("drive", 1'b1, drive_o);
		ticks(64);
		chk1("fan_fault", 1'b1, fan_fault_o);
		clocks(3);
		chk1("fault_n", 1'b1, fault_n_o);
		ticks(2);
		chk1("drive", 1'b0, drive_o);
		$display("test stall done");
	endtask : test_stall

	task automatic test_fault_tie();
		handler_mode = 2'b00;
		demand_i = 8'hFF;
		clocks(2);
		handler_mode = 2'b10;
		ticks(1);
		chk1("fault_n", 1'b0, fault_n_o);
		chk1("drive", 1'b1, drive_o);
		clocks(3);
		chk1("drive", 1'b0, drive_o);
		chk1("fault_n", 1'b1, fault_n_o);
		ticks(1);
		chk1("drive", 1'b0, drive_o);
		$display("test fault_tie done");
	endtask : test_fault_tie

	initial begin
		repeat (10) @(posedge sys_clk_i);
		#1;
		reset_n_i = 1'b1;
		test_powerup_fail();
		test_restart_duty();
		test_overtemp();
		test_stall();
		test_fault_tie();
		print_verdict();
	end
endmodule : tb_fan_pwm_fault_supervisor
